/* rtl/tss_sched_avg.v */
// Function
// (R1) voltage results straight binary, temperature twos complement
// (R2) integration done requests temperature conversion automatically
// (R3) command mode: finish voltage conversion, then temperature
// (R4) idle voltage path: temperature every 5 ms
// (R5) autocycle: slot temperature in sequence, immediate if idle
// (R6) latest temperature result always readable
// (R7) temperature conversions only while sensor enabled
// (R8) average = 7/8 previous plus 1/8 new
// (R9) first result after enable is actual value
// (R10) temperature stored 12-bit, quarter degree steps
// (R11) codes: -40 F60, 0 000, +125 1F4
// (R12) internal reference default, external when selected
// (R13) host waits 5.5 ms for reference buffer
// (R14) short low reset pulse clears all registers
// (R15) reset held beyond 100 ns gives power-down
// (R16) host keeps reset pin at stable level
// (R17) autocycle converts every 50 us
// (R18) host writes command as two bytes, MSB first
// (R19) average seeded from first result after enable
`timescale 1ns/1ps
`include "tss_consts.vh"
module tss_sched_avg #(
   parameter TEMP_PERIOD_CYC = `TSS_TEMP_PERIOD_CYC,
   parameter AUTO_PERIOD_CYC = `TSS_AUTO_PERIOD_CYC,
   parameter REF_SETTLE_CYC = `TSS_REF_SETTLE_CYC
) (
   input wire clk,
   input wire reset_n,
   input wire powerdown_reset_n,
   input wire tsense_enable,
   input wire external_reference_select,
   input wire autocycle_mode,
   input wire volt_conv_req,
   input wire [11:0] volt_raw,
   input wire integ_done,
   input wire conv_done,
   input wire [11:0] conv_raw,
   output reg conv_start,
   output reg conv_is_temp,
   output reg [11:0] volt_result,
   output reg [11:0] temperature_result,
   output reg [11:0] temperature_running_average,
   output reg temp_valid,
   output reg use_external_ref,
   output reg ref_ready,
   output reg full_powerdown,
   output reg converter_awake
);
   localparam S_IDLE = 3'b001;
   localparam S_VOLT = 3'b010;
   localparam S_TEMP = 3'b100;
   localparam TW = 20;
   localparam RW = 4;
   localparam integer RST_MAX_I = `TSS_RST_MAX_CYC;
   localparam [TW-1:0] TEMP_P = TEMP_PERIOD_CYC[TW-1:0];
   localparam [TW-1:0] AUTO_P = AUTO_PERIOD_CYC[TW-1:0];
   localparam [TW-1:0] REF_P = REF_SETTLE_CYC[TW-1:0];
   localparam [RW-1:0] RST_MAX = RST_MAX_I[RW-1:0];

   reg [1:0] pd_sync_reg;
   reg [1:0] en_sync_reg;
   reg [1:0] ext_sync_reg;
   reg [1:0] auto_sync_reg;
   reg [1:0] vreq_sync_reg;
   reg [1:0] integ_sync_reg;
   reg [1:0] done_sync_reg;
   reg integ_prev_reg;
   reg done_prev_reg;
   reg vreq_prev_reg;
   reg [RW-1:0] low_cnt_reg;
   wire soft_rst;
   wire pd_low;
   wire enabled;
   wire integ_rise;
   wire done_rise;
   wire vreq_rise;

   // all async pins go through two stages; first stage read only by second
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_sync_reg <= 2'h3;
         en_sync_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
         auto_sync_reg <= 2'h0;
         vreq_sync_reg <= 2'h0;
         integ_sync_reg <= 2'h0;
         done_sync_reg <= 2'h0;
      end else begin
         pd_sync_reg <= {pd_sync_reg[0], powerdown_reset_n};
         en_sync_reg <= {en_sync_reg[0], tsense_enable};
         ext_sync_reg <= {ext_sync_reg[0], external_reference_select};
         auto_sync_reg <= {auto_sync_reg[0], autocycle_mode};
         vreq_sync_reg <= {vreq_sync_reg[0], volt_conv_req};
         integ_sync_reg <= {integ_sync_reg[0], integ_done};
         done_sync_reg <= {done_sync_reg[0], conv_done};
      end
   end

   assign pd_low = ~pd_sync_reg[1];
   // any low pulse clears state; a pulse shorter than a clock may be missed here,
   // so reset_n should be tied to the same pin by the integrator
   assign soft_rst = pd_low; // R14
   assign enabled = en_sync_reg[1];
   assign integ_rise = integ_sync_reg[1] & ~integ_prev_reg;
   assign done_rise = done_sync_reg[1] & ~done_prev_reg;
   assign vreq_rise = vreq_sync_reg[1] & ~vreq_prev_reg;

   // long low level means power-down as well as reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         low_cnt_reg <= 4'h0;
         full_powerdown <= 1'b0;
      end else if (!pd_low) begin
         low_cnt_reg <= 4'h0;
         full_powerdown <= 1'b0;
      end else begin
         if (low_cnt_reg <= RST_MAX)
            low_cnt_reg <= low_cnt_reg + 4'h1;
         if (low_cnt_reg >= RST_MAX)
            full_powerdown <= 1'b1; // R15
      end
   end

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg temp_pend_reg;
   reg volt_pend_reg;
   reg first_reg;
   reg [TW-1:0] tper_reg;
   reg [TW-1:0] aper_reg;
   reg [TW-1:0] ref_cnt_reg;
   reg start_temp;
   reg start_volt;
   wire [14:0] avg_ext;
   wire [14:0] cur_ext;
   wire [14:0] avg_sum;
   wire tper_hit;
   wire aper_hit;

   // work in 15 bits so the signed 7/8 + 1/8 blend cannot overflow
   assign avg_ext = {{3{temperature_running_average[11]}}, temperature_running_average};
   assign cur_ext = {{3{conv_raw[11]}}, conv_raw};
   assign avg_sum = avg_ext - (avg_ext >>> `TSS_AVG_SHIFT) + (cur_ext >>> `TSS_AVG_SHIFT);
   assign tper_hit = (tper_reg >= TEMP_P - 20'h00001);
   assign aper_hit = (aper_reg >= AUTO_P - 20'h00001);

   always @* begin
      start_temp = 1'b0;
      start_volt = 1'b0;
      state_next = state_reg;
      case (state_reg)
         S_IDLE: begin
            // temperature goes first whenever both wait, whichever was requested first
            if (temp_pend_reg && enabled) begin // R5
               start_temp = 1'b1;
               state_next = S_TEMP;
            end else if (volt_pend_reg) begin
               start_volt = 1'b1;
               state_next = S_VOLT;
            end
         end
         S_VOLT: begin
            if (done_rise)
               state_next = S_IDLE; // R3
         end
         S_TEMP: begin
            if (done_rise)
               state_next = S_IDLE;
         end
         default: state_next = S_IDLE;
      endcase
   end

   // edge detectors rest low, the idle level of all three inputs
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         integ_prev_reg <= 1'b0;
         done_prev_reg <= 1'b0;
         vreq_prev_reg <= 1'b0;
      end else if (soft_rst) begin
         integ_prev_reg <= 1'b0;
         done_prev_reg <= 1'b0;
         vreq_prev_reg <= 1'b0;
      end else begin
         integ_prev_reg <= integ_sync_reg[1];
         done_prev_reg <= done_sync_reg[1];
         vreq_prev_reg <= vreq_sync_reg[1];
      end
   end

   // reference select and buffer settle; an external reference is ready at once
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         use_external_ref <= 1'b0;
         ref_cnt_reg <= 20'h00000;
         ref_ready <= 1'b0;
      end else if (soft_rst) begin
         use_external_ref <= 1'b0;
         ref_cnt_reg <= 20'h00000;
         ref_ready <= 1'b0;
      end else begin
         use_external_ref <= ext_sync_reg[1]; // R12
         // settle count restarts whenever the internal reference comes back
         if (ext_sync_reg[1]) begin
            ref_cnt_reg <= 20'h00000;
            ref_ready <= 1'b1;
         end else if (ref_cnt_reg < REF_P) begin
            ref_cnt_reg <= ref_cnt_reg + 20'h00001;
            ref_ready <= 1'b0;
         end else
            ref_ready <= 1'b1;
      end
   end

   // interval timers for the periodic temperature slot and autocycle wake-ups
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tper_reg <= 20'h00000;
         aper_reg <= 20'h00000;
      end else if (soft_rst) begin
         tper_reg <= 20'h00000;
         aper_reg <= 20'h00000;
      end else begin
         // the slot only counts while the voltage path is quiet
         if (state_reg == S_VOLT || volt_pend_reg || !enabled || tper_hit)
            tper_reg <= 20'h00000;
         else
            tper_reg <= tper_reg + 20'h00001;
         // wake-ups run free in autocycle, even through a long conversion
         if (!auto_sync_reg[1] || aper_hit)
            aper_reg <= 20'h00000;
         else
            aper_reg <= aper_reg + 20'h00001;
      end
   end

   // one conversion at a time; a request that comes while busy stays pending
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= S_IDLE;
         temp_pend_reg <= 1'b0;
         volt_pend_reg <= 1'b0;
         conv_start <= 1'b0;
         conv_is_temp <= 1'b0;
         converter_awake <= 1'b0;
      end else if (soft_rst) begin
         state_reg <= S_IDLE; // R14
         temp_pend_reg <= 1'b0;
         volt_pend_reg <= 1'b0;
         conv_start <= 1'b0;
         conv_is_temp <= 1'b0;
         converter_awake <= 1'b0;
      end else begin
         state_reg <= state_next;
         conv_start <= start_temp | start_volt;
         if (start_temp | start_volt)
            conv_is_temp <= start_temp;
         converter_awake <= (state_next != S_IDLE); // R17
         // pending set wins over the clear from a start in the same cycle
         if (enabled && (integ_rise || tper_hit)) // R2 R4
            temp_pend_reg <= 1'b1;
         else if (start_temp || !enabled)
            temp_pend_reg <= 1'b0; // R7
         if ((!auto_sync_reg[1] && vreq_rise) || (auto_sync_reg[1] && aper_hit)) // R17
            volt_pend_reg <= 1'b1;
         else if (start_volt)
            volt_pend_reg <= 1'b0;
      end
   end

   // results stand until the next conversion of their kind ends
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         first_reg <= 1'b1;
         volt_result <= 12'h000;
         temperature_result <= `TSS_CODE_ZERO;
         temperature_running_average <= `TSS_CODE_ZERO;
         temp_valid <= 1'b0;
      end else if (soft_rst) begin
         first_reg <= 1'b1;
         volt_result <= 12'h000;
         temperature_result <= `TSS_CODE_ZERO;
         temperature_running_average <= `TSS_CODE_ZERO;
         temp_valid <= 1'b0;
      end else begin
         if (!enabled) begin
            first_reg <= 1'b1;
            temp_valid <= 1'b0;
         end
         if (done_rise && state_reg == S_VOLT)
            volt_result <= volt_raw; // R1
         // a temperature result that ends after disable is dropped, not averaged
         if (done_rise && state_reg == S_TEMP && enabled) begin
            temperature_result <= conv_raw; // R6 R10 R11
            temp_valid <= 1'b1; // R9
            first_reg <= 1'b0;
            if (first_reg)
               temperature_running_average <= conv_raw; // R19
            else
               temperature_running_average <= avg_sum[11:0]; // R8
         end
      end
   end
endmodule

/* rtl/tss_consts.vh */
`ifndef TSS_CONSTS_VH
`define TSS_CONSTS_VH
// temperature code width and quarter-degree coding
`define TSS_CODE_W 12
`define TSS_CODE_ZERO 12'h000
// periodic temperature slot when voltage path is quiet
`define TSS_TEMP_PERIOD_US 5000
`define TSS_TEMP_PERIOD_CYC (`TSS_TEMP_PERIOD_US * 100)
// autocycle wake interval
`define TSS_AUTO_PERIOD_US 50
`define TSS_AUTO_PERIOD_CYC (`TSS_AUTO_PERIOD_US * 100)
// reset pulse longest width; longer means full power-down
`define TSS_RST_MAX_NS 100
`define TSS_RST_MAX_CYC (`TSS_RST_MAX_NS / 10)
// reference buffer settle time
`define TSS_REF_SETTLE_US 5500
`define TSS_REF_SETTLE_CYC (`TSS_REF_SETTLE_US * 100)
// averaging weights: new = prev - prev/8 + cur/8
`define TSS_AVG_SHIFT 3
`define TSS_CMD_TSENSE_BIT 7
`endif

/* dv/tss_sched_avg_assertions.sv */
`timescale 1ns/1ps
module tss_sched_avg_assertions (
   input wire clk,
   input wire reset_n,
   input wire powerdown_reset_n,
   input wire tsense_enable,
   input wire external_reference_select,
   input wire conv_start,
   input wire conv_is_temp,
   input wire converter_awake,
   input wire [11:0] temperature_result,
   input wire [11:0] temperature_running_average,
   input wire temp_valid,
   input wire use_external_ref,
   input wire full_powerdown
);
   reg [3:0] pd_low_reg;
   reg [2:0] en_low_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // saturating run lengths of the pin low and of the sensor off
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pd_low_reg <= 4'h0;
         en_low_reg <= 3'h0;
      end else begin
         pd_low_reg <= powerdown_reset_n ? 4'h0 : pd_low_reg + {3'h0, pd_low_reg != 4'hF};
         en_low_reg <= tsense_enable ? 3'h0 : en_low_reg + {2'h0, en_low_reg != 3'h7};
      end
   end
   a_start_one_pulse: assert property (conv_start |=> !conv_start)
      else $error("start pulse too long");
   a_start_when_idle: assert property (conv_start |-> !$past(converter_awake))
      else $error("start while busy");
   a_temp_needs_enable: assert property (en_low_reg == 3'h7 |-> !(conv_start && conv_is_temp))
      else $error("temperature start while disabled");
   a_avg_seed_first: assert property ($rose(temp_valid) |->
      temperature_running_average == temperature_result)
      else $error("average not seeded");
   a_pin_clears_state: assert property (pd_low_reg >= 4'h5 |->
      !temp_valid && temperature_result == 12'h000 && !conv_start)
      else $error("state not cleared");
   a_powerdown_entry: assert property ($rose(full_powerdown) |-> pd_low_reg >= 4'h8)
      else $error("power-down too early");
   a_short_pulse_reset: assert property ($rose(powerdown_reset_n) && pd_low_reg < 4'h4 |->
      !full_powerdown [*8])
      else $error("short pulse gave power-down");
   a_external_reference_select_follows: assert property ((external_reference_select && powerdown_reset_n) [*5] |->
      use_external_ref)
      else $error("external reference not taken");
   cover property (conv_start && conv_is_temp);
   cover property (conv_start && !conv_is_temp);
   cover property ($rose(full_powerdown));
endmodule
bind tss_sched_avg tss_sched_avg_assertions u_chk (.clk, .reset_n, .powerdown_reset_n,
   .tsense_enable, .external_reference_select, .conv_start, .conv_is_temp, .converter_awake,
   .temperature_result, .temperature_running_average, .temp_valid, .use_external_ref,
   .full_powerdown);

/* dv/tss_conv_model.sv */
`timescale 1ns/1ps
module tss_conv_model (
   input wire clk,
   input wire conv_start,
   input wire [7:0] lat,
   input wire [11:0] tcode,
   input wire [11:0] vcode,
   output reg conv_done,
   output reg [11:0] conv_raw,
   output reg [11:0] volt_raw
);
   initial begin
      conv_done = 1'b0;
      conv_raw = 12'hAAA;
      volt_raw = 12'h555;
      forever begin
         @(posedge clk);
         if (conv_start === 1'b1) begin
            repeat (lat) @(posedge clk);
            conv_raw <= tcode;
            volt_raw <= vcode;
            conv_done <= 1'b1;
            repeat (4) @(posedge clk);
            conv_done <= 1'b0;
            // data stops holding once done falls, so a late sample sees garbage;
            // back to watching starts at once, a queued start follows within a cycle
            conv_raw <= ~tcode;
            volt_raw <= ~vcode;
         end
      end
   end
endmodule

/* dv/tb_temp_sensor_sched_average.sv */
`timescale 1ns/1ps
module tb_temp_sensor_sched_average;
   reg clk = 1'b0, reset_n = 1'b0, pd_n = 1'b1, en = 1'b0, ext = 1'b0;
   reg acyc = 1'b0, vreq = 1'b0, integ = 1'b0, seeded = 1'b0;
   reg [7:0] lat = 8'h03;
   reg [11:0] tcode = 12'h000, vcode = 12'h000;
   reg [31:0] rnd = 32'hD1A33472;
   wire cs, cit, tv, uxr, rr, fpd, aw, cd;
   wire [11:0] vr, tr, ta, craw, vraw;
   integer n_fail = 0, comparisons = 0, nst = 0, ntt = 0, avg, t0, i, k;
   tss_sched_avg #(.TEMP_PERIOD_CYC(2000), .AUTO_PERIOD_CYC(50), .REF_SETTLE_CYC(100)) uut (
      .clk(clk), .reset_n(reset_n), .powerdown_reset_n(pd_n), .tsense_enable(en),
      .external_reference_select(ext), .autocycle_mode(acyc), .volt_conv_req(vreq),
      .volt_raw(vraw), .integ_done(integ), .conv_done(cd), .conv_raw(craw), .conv_start(cs),
      .conv_is_temp(cit), .volt_result(vr), .temperature_result(tr),
      .temperature_running_average(ta), .temp_valid(tv), .use_external_ref(uxr),
      .ref_ready(rr), .full_powerdown(fpd), .converter_awake(aw));
   tss_conv_model partner (.clk(clk), .conv_start(cs), .lat(lat), .tcode(tcode),
      .vcode(vcode), .conv_done(cd), .conv_raw(craw), .volt_raw(vraw));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task chk(input [11:0] got, input [11:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         n_fail = n_fail + 1;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task test_done;
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task pulse_integ;
      integ = 1'b1;
      @(negedge clk);
      integ = 1'b0;
   endtask
   // command word goes out high byte first; the sensor enable sits in the low byte
   task send_cmd(input [7:0] first_byte, input [7:0] second_byte);
      reg [15:0] cmd;
      cmd = {first_byte, second_byte};
      en = cmd[7];
   endtask
   task wait_start(input t);
      @(negedge clk);
      for (i = 0; i < 80 && cs !== 1'b1; i = i + 1) @(negedge clk);
      chk({11'h0, cs}, 12'h001);
      chk({11'h0, cit}, {11'h0, t});
      chk({11'h0, aw}, 12'h001);
   endtask
   task tconv(input [11:0] c, input vfirst);
      integer sc;
      tcode = c;
      vcode = rnd[23:12];
      if (vfirst) begin
         vreq = 1'b1;
         wait_start(1'b0);
         vreq = 1'b0;
      end
      pulse_integ;
      wait_start(1'b1);
      repeat (lat + 12) @(negedge clk);
      sc = {{20{c[11]}}, c};
      avg = seeded ? avg - (avg >>> 3) + (sc >>> 3) : sc;
      seeded = 1'b1;
      chk(tr, c);
      chk(ta, avg[11:0]);
      chk({11'h0, tv}, 12'h001);
      chk({11'h0, aw}, 12'h000);
      if (vfirst) chk(vr, vcode);
   endtask
   always @(negedge clk) if (cs === 1'b1) begin
      nst = nst + 1;
      ntt = ntt + (cit === 1'b1);
   end
   initial forever #5 clk = ~clk;
   initial begin
      #200000;
      n_fail = n_fail + 1;
      test_done;
   end
   initial begin
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      @(negedge clk);
      chk({tr[11:1], rr}, 12'h000);
      send_cmd(8'h00, 8'h80);
      // results are trusted only once the internal reference has settled
      while (rr !== 1'b1) @(negedge clk);
      repeat (4) @(negedge clk);
      for (k = 0; k < 8; k = k + 1) begin
         rnd = lfsr(rnd);
         lat = k > 5 ? 8'h14 : 8'h03;
         tconv(k == 0 ? 12'hF60 : k == 1 ? 12'h000 : k == 2 ? 12'h1F4 : rnd[11:0], k > 5);
      end
      send_cmd(8'h00, 8'h00);
      repeat (8) @(negedge clk);
      t0 = nst;
      pulse_integ;
      repeat (60) @(negedge clk);
      chk(12'(nst - t0), 12'h000);
      chk(tr, tcode);
      // re-enable with no trigger: only the periodic slot can convert
      send_cmd(8'h00, 8'h80);
      t0 = ntt;
      repeat (2100) @(negedge clk);
      chk(12'(ntt > t0), 12'h001);
      chk(ta, tcode);
      acyc = 1'b1;
      t0 = nst - ntt;
      repeat (100) @(negedge clk);
      k = ntt;
      pulse_integ;
      repeat (110) @(negedge clk);
      acyc = 1'b0;
      chk(12'(ntt > k), 12'h001);
      chk(12'(nst - ntt - t0 >= 3), 12'h001);
      chk({11'h0, rr}, 12'h001);
      ext = 1'b1;
      repeat (6) @(negedge clk);
      chk({11'h0, uxr}, 12'h001);
      chk({11'h0, rr}, 12'h001);
      ext = 1'b0;
      repeat (6) @(negedge clk);
      chk({11'h0, uxr}, 12'h000);
      chk({11'h0, rr}, 12'h000);
      pd_n = 1'b0;
      repeat (3) @(negedge clk);
      pd_n = 1'b1;
      repeat (6) @(negedge clk);
      chk(tr, 12'h000);
      chk({10'h0, tv, fpd}, 12'h000);
      pd_n = 1'b0;
      repeat (20) @(negedge clk);
      chk({11'h0, fpd}, 12'h001);
      pd_n = 1'b1;
      repeat (6) @(negedge clk);
      chk({11'h0, fpd}, 12'h000);
      test_done;
   end
endmodule
